// >>> emc_pkg.sv
// Package for exception mask and mode control block
package emc_pkg;
  // Register word offsets (byte addresses)
  localparam logic [4:0] ADDR_GMASK = 5'h00;
  localparam logic [4:0] ADDR_FMASK = 5'h04;
  localparam logic [4:0] ADDR_THRESH = 5'h08;
  localparam logic [4:0] ADDR_MODE = 5'h0c;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  // Field positions
  localparam int MODE_USER_BIT = 0;
  localparam int MODE_SPSEL_BIT = 1;
  // Reset values
  localparam logic GMASK_RST = 1'h0;
  localparam logic FMASK_RST = 1'h0;
  localparam logic [8:0] THRESH_RST = 9'h000;
  localparam logic [1:0] MODE_RST = 2'h0;
  // Exception numbers
  localparam int NUM_SYS = 16;
  localparam int NUM_IRQ = 32;
  localparam int NUM_EXC = NUM_SYS + NUM_IRQ;
  localparam logic [5:0] EXC_NMI = 6'h02;
  localparam logic [5:0] EXC_HARD = 6'h03;
  localparam logic [5:0] EXC_NONE = 6'h00;

  typedef enum logic [1:0] {
    EMC_IDLE,
    EMC_ACK
  } emc_bus_st_t;

  typedef struct packed {
    logic [3:0] adr;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
    logic cyc;
    logic stb;
  } emc_wb_req_t;

  typedef struct packed {
    logic gmask;
    logic fmask;
    logic [8:0] thresh;
    logic [1:0] mode;
    emc_bus_st_t bus;
    logic ack;
    logic [31:0] rdat;
    logic [5:0] act_num;
    logic act_vld;
    logic escalated;
    logic user_lvl;
    logic use_psp;
  } emc_state_t;
endpackage

// >>> emc_src_model.sv
// Exception source model holding requests until taken or flushed
`timescale 1ns/10ps
module emc_src_model
  import emc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bench control
  input wire logic [NUM_EXC-1:0] raise,
  input wire logic flush,
  input wire logic take,
  // Pipeline view
  input wire logic exc_act_vld,
  input wire logic [5:0] exc_act_num,
  output logic [NUM_EXC-1:0] exc_pend
);
  logic [NUM_EXC-1:0] pend_ff;
  logic [NUM_EXC-1:0] nxt_pend;
  always_comb begin
    nxt_pend = (flush ? '0 : pend_ff) | raise;
    if (take && exc_act_vld && exc_act_num < 6'h30) begin
      nxt_pend[exc_act_num] = 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end
  assign exc_pend = pend_ff;
endmodule

// >>> emc_top.sv
// Exception mask and mode control with classic Wishbone registers
//
// Function
// - Global mask set lets only NMI and hard fault activate.
// - Fault mask set lets only NMI activate.
// - Threshold blocks interrupts of priority value at or above it.
// - Threshold of zero disables priority masking.
// - Mode bit 0 selects privileged (0) or user (1) thread level.
// - Mode bit 1 selects main (0) or alternate (1) stack pointer.
// - In thread or user level the alternate stack is the process one.
// - Handler mode has no alternate stack and always uses main stack.
// - A fault whose handler is masked or disabled escalates to hard fault.
// - Masks cover 16 system exceptions and 32 peripheral interrupts.
`timescale 1ns/10ps
module emc_top
  import emc_pkg::*;
#(
  parameter int PRIO_W = 9
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Exception sources, held pending by the sources
  input wire logic [NUM_EXC-1:0] exc_pend,
  input wire logic [NUM_EXC-1:0] exc_enable,
  input wire logic [NUM_EXC*PRIO_W-1:0] exc_prio,
  // Pipeline side
  input wire logic handler_mode,
  output logic exc_act_vld,
  output logic [5:0] exc_act_num,
  output logic fault_escalated,
  output logic thread_user,
  output logic sp_process_sel
);

  emc_state_t st_ff;
  emc_state_t nxt_st;

  function automatic logic is_fault(input int n);
    return (n >= 4) && (n <= 6);
  endfunction

  function automatic logic is_resv(input int n);
    return (n == 0) || (n == 1) || ((n >= 7) && (n <= 10)) || (n == 13);
  endfunction

  // Mask check for one exception number
  function automatic logic allowed(input int n, input logic gm,
                                   input logic fm, input logic [8:0] th,
                                   input logic [PRIO_W-1:0] pr);
    logic ok;
    ok = 1'b1;
    if (fm && (n != int'(EXC_NMI))) begin
      ok = 1'b0;
    end
    if (gm && (n != int'(EXC_NMI)) && (n != int'(EXC_HARD))) begin
      ok = 1'b0;
    end
    if ((th != 9'h000) && (n > int'(EXC_HARD)) &&
        (9'(pr) >= th)) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  logic [4:0] word_adr;
  assign word_adr = wb_adr_i[4:0];

  always_comb begin
    logic found;
    logic esc;
    logic hard_pend;
    logic [PRIO_W-1:0] pr;
    found = 1'b0;
    esc = 1'b0;
    hard_pend = 1'b0;
    pr = '0;
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    // Register bus
    case (st_ff.bus)
      EMC_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          nxt_st.ack = 1'b1;
          nxt_st.bus = EMC_ACK;
          nxt_st.rdat = 32'h0000_0000;
          case (word_adr)
            5'(ADDR_GMASK): begin
              nxt_st.rdat = {31'h0, st_ff.gmask};
              if (wb_we_i && wb_sel_i[0]) begin
                nxt_st.gmask = wb_dat_i[0];
              end
            end
            5'(ADDR_FMASK): begin
              nxt_st.rdat = {31'h0, st_ff.fmask};
              if (wb_we_i && wb_sel_i[0]) begin
                nxt_st.fmask = wb_dat_i[0];
              end
            end
            5'(ADDR_THRESH): begin
              nxt_st.rdat = {23'h0, st_ff.thresh};
              if (wb_we_i && wb_sel_i[0]) begin
                nxt_st.thresh[7:0] = wb_dat_i[7:0];
              end
              if (wb_we_i && wb_sel_i[1]) begin
                nxt_st.thresh[8] = wb_dat_i[8];
              end
            end
            5'(ADDR_MODE): begin
              nxt_st.rdat = {30'h0, st_ff.mode};
              if (wb_we_i && wb_sel_i[0]) begin
                nxt_st.mode[MODE_USER_BIT] = wb_dat_i[MODE_USER_BIT];
                // Stack select stays 0 in handler mode
                nxt_st.mode[MODE_SPSEL_BIT] = wb_dat_i[MODE_SPSEL_BIT] &
                                              ~handler_mode;
              end
            end
            ADDR_STATUS: begin
              nxt_st.rdat = {20'h0, st_ff.escalated, st_ff.act_vld,
                             st_ff.act_num, st_ff.use_psp, st_ff.user_lvl,
                             2'h0};
            end
            default: nxt_st.rdat = 32'h0000_0000;
          endcase
        end
      end
      EMC_ACK: nxt_st.bus = EMC_IDLE;
      default: nxt_st.bus = EMC_IDLE;
    endcase
    if (handler_mode) begin
      nxt_st.mode[MODE_SPSEL_BIT] = 1'b0;
    end
    // Fault escalation: a pending fault that cannot be taken
    for (int n = 4; n <= 6; n++) begin
      pr = exc_prio[n*PRIO_W +: PRIO_W];
      if (exc_pend[n] && is_fault(n) &&
          (!exc_enable[n] ||
           !allowed(n, st_ff.gmask, st_ff.fmask, st_ff.thresh, pr))) begin
        esc = 1'b1;
      end
    end
    hard_pend = exc_pend[EXC_HARD] | esc;
    // Selection; lowest number wins, requests are only held off
    nxt_st.act_vld = 1'b0;
    nxt_st.act_num = EXC_NONE;
    for (int n = 2; n < NUM_EXC; n++) begin
      pr = exc_prio[n*PRIO_W +: PRIO_W];
      if (!found && !is_resv(n)) begin
        if (n == int'(EXC_HARD)) begin
          if (hard_pend && allowed(n, st_ff.gmask, st_ff.fmask,
                                   st_ff.thresh, pr)) begin
            found = 1'b1;
            nxt_st.act_num = EXC_HARD;
          end
        end else if (exc_pend[n] && (exc_enable[n] || n == 2) &&
                     allowed(n, st_ff.gmask, st_ff.fmask,
                             st_ff.thresh, pr)) begin
          found = 1'b1;
          nxt_st.act_num = 6'(n);
        end
      end
    end
    nxt_st.act_vld = found;
    nxt_st.escalated = esc;
    nxt_st.user_lvl = st_ff.mode[MODE_USER_BIT] & ~handler_mode;
    nxt_st.use_psp = st_ff.mode[MODE_SPSEL_BIT] &
                     ~handler_mode;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '{gmask: GMASK_RST, fmask: FMASK_RST, thresh: THRESH_RST,
                 mode: MODE_RST, bus: EMC_IDLE, ack: 1'b0,
                 rdat: 32'h0000_0000, act_num: EXC_NONE, act_vld: 1'b0,
                 escalated: 1'b0, user_lvl: 1'b0, use_psp: 1'b0};
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o = st_ff.rdat;
  assign wb_ack_o = st_ff.ack;
  assign exc_act_vld = st_ff.act_vld;
  assign exc_act_num = st_ff.act_num;
  assign fault_escalated = st_ff.escalated;
  assign thread_user = st_ff.user_lvl;
  assign sp_process_sel = st_ff.use_psp;

  // Priority of the number chosen this cycle
  logic [PRIO_W-1:0] sel_prio;
  assign sel_prio = exc_prio[nxt_st.act_num*PRIO_W +: PRIO_W];

  // Assertions
  property p_fmask_only_nmi;
    @(posedge sys_clk) disable iff (!rst_b)
    clk_en && st_ff.fmask |=> !exc_act_vld || exc_act_num == EXC_NMI;
  endproperty
  a_fmask_only_nmi: assert property (p_fmask_only_nmi)
    else $error("fault mask let a non-NMI through");

  property p_gmask_nmi_hard;
    @(posedge sys_clk) disable iff (!rst_b)
    clk_en && st_ff.gmask |=> !exc_act_vld ||
      exc_act_num == EXC_NMI || exc_act_num == EXC_HARD;
  endproperty
  a_gmask_nmi_hard: assert property (p_gmask_nmi_hard)
    else $error("global mask let a maskable exception through");

  property p_thresh_block;
    @(posedge sys_clk) disable iff (!rst_b)
    clk_en && st_ff.thresh != 9'h000 && nxt_st.act_vld &&
      nxt_st.act_num > EXC_HARD |-> 9'(sel_prio) < st_ff.thresh;
  endproperty
  a_thresh_block: assert property (p_thresh_block)
    else $error("threshold failed to block");

  property p_thresh_zero;
    @(posedge sys_clk) disable iff (!rst_b)
    clk_en && st_ff.thresh == 9'h000 && !st_ff.gmask && !st_ff.fmask &&
      exc_pend[16] && exc_enable[16] && exc_pend[15:2] == '0
      |=> exc_act_vld;
  endproperty
  a_thresh_zero: assert property (p_thresh_zero)
    else $error("zero threshold still masks");

  property p_user_lvl;
    @(posedge sys_clk) disable iff (!rst_b)
    clk_en |=> thread_user == ($past(st_ff.mode[0]) & ~$past(handler_mode));
  endproperty
  a_user_lvl: assert property (p_user_lvl)
    else $error("thread level output wrong");

  property p_psp_sel;
    @(posedge sys_clk) disable iff (!rst_b)
    clk_en && !handler_mode && st_ff.mode[1] |=> sp_process_sel;
  endproperty
  a_psp_sel: assert property (p_psp_sel)
    else $error("process stack not selected");

  property p_psp_thread;
    @(posedge sys_clk) disable iff (!rst_b)
    sp_process_sel |-> $past(st_ff.mode[1]);
  endproperty
  a_psp_thread: assert property (p_psp_thread)
    else $error("process stack without select bit");

  property p_handler_msp;
    @(posedge sys_clk) disable iff (!rst_b)
    clk_en && handler_mode |=> !sp_process_sel && !st_ff.mode[1];
  endproperty
  a_handler_msp: assert property (p_handler_msp)
    else $error("alternate stack in handler mode");

  property p_escalate;
    @(posedge sys_clk) disable iff (!rst_b)
    clk_en && exc_pend[4] && !exc_enable[4] |=> fault_escalated;
  endproperty
  a_escalate: assert property (p_escalate)
    else $error("masked fault not escalated");

  property p_ack_one;
    @(posedge sys_clk) disable iff (!rst_b)
    wb_ack_o && clk_en |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack longer than one cycle");

  c_nmi: cover property (@(posedge sys_clk) exc_act_vld &&
                         exc_act_num == EXC_NMI);
  c_hard: cover property (@(posedge sys_clk) fault_escalated);
  c_psp: cover property (@(posedge sys_clk) sp_process_sel);
endmodule

// >>> exception_mask_and_mode_control_tb.sv
// Self-checking bench for exception mask and mode control
`timescale 1ns/10ps
module exception_mask_and_mode_control_tb
  import emc_pkg::*;
;
  logic sys_clk = 0, rst_b = 0, clk_en = 0, handler_mode = 0;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, flush = 0, take = 0;
  logic [4:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, rd, seed = 32'h08646f8f;
  logic wb_ack_o, exc_act_vld, fault_escalated, thread_user, sp_process_sel;
  logic [5:0] exc_act_num;
  logic [NUM_EXC-1:0] exc_pend, exc_enable = '1, raise = '0, p;
  logic [NUM_EXC*9-1:0] exc_prio = '0;
  logic gm, fm;
  logic [8:0] th;
  int num_errors = 0, n_tests = 0;

  always #20 sys_clk = ~sys_clk;

  emc_top u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .exc_pend(exc_pend),
    .exc_enable(exc_enable), .exc_prio(exc_prio),
    .handler_mode(handler_mode), .exc_act_vld(exc_act_vld),
    .exc_act_num(exc_act_num), .fault_escalated(fault_escalated),
    .thread_user(thread_user), .sp_process_sel(sp_process_sel));
  emc_src_model u_src (.sys_clk(sys_clk), .rst_b(rst_b), .raise(raise),
    .flush(flush), .take(take), .exc_act_vld(exc_act_vld),
    .exc_act_num(exc_act_num), .exc_pend(exc_pend));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [6:0] exp_act(input logic [47:0] q);
    logic ok;
    for (int n = 0; n < 48; n++) begin
      ok = q[n] && (exc_enable[n] || n == 2 || n == 3);
      if (fm && n != 2) ok = 0;
      if (gm && n > 3) ok = 0;
      if (th != 0 && n > 3 && exc_prio[n*9 +: 9] >= th) ok = 0;
      if (ok) return {1'b1, 6'(n)};
    end
    return 7'h00;
  endfunction

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    i = 0;
    do begin
      @(negedge sys_clk);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 50);
    if (i >= 50) num_errors++;
    rd = wb_dat_o;
    @(posedge sys_clk);
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask

  task automatic pend(input logic [47:0] v);
    @(posedge sys_clk);
    raise <= v;
    flush <= 1;
    @(posedge sys_clk);
    raise <= '0;
    flush <= 0;
    p = v;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic conclude();
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1;
    clk_en <= 1;
    wb(1, 5'h14, 32'hffff);
    for (int a = 0; a < 6; a++) begin
      wb(0, 5'(a * 4), 0);
      chk(rd, 0);
    end
    for (int k = 0; k < 150; k++) begin
      gm = rnd() % 4 == 0;
      fm = rnd() % 4 == 0;
      th = rnd() % 2 ? 9'h000 : rnd() % 9'h100;
      wb(1, 5'h00, gm);
      wb(1, 5'h04, fm);
      wb(1, 5'h08, th);
      wb(0, 5'h08, 0);
      chk(rd, th);
      for (int n = 0; n < 48; n++) exc_prio[n*9 +: 9] <= rnd() % 9'h120;
      exc_enable <= {rnd(), rnd()};
      pend({rnd(), rnd()} & 48'hffff_ffff_d80c);
      chk({exc_act_vld, exc_act_vld ? exc_act_num : 6'h0}, exp_act(p));
    end
    gm = 1;
    fm = 0;
    th = 0;
    wb(1, 5'h04, 0);
    wb(1, 5'h08, 0);
    wb(1, 5'h00, 1);
    exc_enable <= 48'hffff_ffff_ffef;
    pend(48'h1 << 20);
    chk(exc_act_vld, 0);
    wb(1, 5'h00, 0);
    repeat (3) @(posedge sys_clk);
    chk({exc_act_vld, exc_act_num}, 7'h54);
    take <= 1;
    pend(48'h10);
    take <= 0;
    chk(fault_escalated, 1);
    clk_en <= 0;
    exc_enable <= '1;
    repeat (3) @(posedge sys_clk);
    chk(fault_escalated, 1);
    clk_en <= 1;
    repeat (3) @(posedge sys_clk);
    chk(fault_escalated, 0);
    for (int m = 0; m < 4; m++) begin
      handler_mode <= 0;
      wb(1, 5'h0c, m);
      repeat (3) @(posedge sys_clk);
      chk({thread_user, sp_process_sel}, {m[0], m[1]});
      handler_mode <= 1;
      wb(1, 5'h0c, m);
      repeat (3) @(posedge sys_clk);
      chk({thread_user, sp_process_sel, rd[1]}, 0);
      wb(0, 5'h0c, 0);
      chk(rd[1], 0);
    end
    conclude();
  end
endmodule
